// File: hdl/scsdrv_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scsdrv_if;
    import scsdrv_pkg::*;

    // ****************************************
    // Per-party drivers, enables active low
    // ****************************************
    logic [CTL_W-1:0] i_ctl_out;
    logic [CTL_W-1:0] i_ctl_oe_n;
    logic [DB_W-1:0]  i_db_out;
    logic [DB_W-1:0]  i_db_oe_n;
    logic [LANES-1:0] i_par_out;
    logic [LANES-1:0] i_par_oe_n;
    logic [CTL_W-1:0] t_ctl_out;
    logic [CTL_W-1:0] t_ctl_oe_n;
    logic [DB_W-1:0]  t_db_out;
    logic [DB_W-1:0]  t_db_oe_n;
    logic [LANES-1:0] t_par_out;
    logic [LANES-1:0] t_par_oe_n;

    // ****************************************
    // Resolved line levels, released lines pull false
    // ****************************************
    logic [CTL_W-1:0] ctl;
    logic [DB_W-1:0]  db;
    logic [LANES-1:0] par;

    // A line is true when any enabled driver shows true
    assign ctl = (i_ctl_out & ~i_ctl_oe_n) | (t_ctl_out & ~t_ctl_oe_n);
    assign db  = (i_db_out & ~i_db_oe_n) | (t_db_out & ~t_db_oe_n);
    assign par = (i_par_out & ~i_par_oe_n) | (t_par_out & ~t_par_oe_n);

    modport init (
        output i_ctl_out, i_ctl_oe_n, i_db_out, i_db_oe_n, i_par_out, i_par_oe_n,
        input  ctl, db, par
    );
    modport targ (
        output t_ctl_out, t_ctl_oe_n, t_db_out, t_db_oe_n, t_par_out, t_par_oe_n,
        input  ctl, db, par
    );
endinterface
`default_nettype wire

// File: hdl/scsdrv_init.sv
`timescale 1ns/1ps
`default_nettype none
module scsdrv_init
    import scsdrv_pkg::*;
(
    input  wire logic            sys_clk_in,
    input  wire logic            sys_rst_in,
    input  wire scsdrv_phase_e   phase_in,
    input  wire logic [2:0]      own_id_in,
    input  wire logic            contend_in,
    input  wire logic            won_in,
    input  wire logic            bsy_in,
    input  wire logic            sel_in,
    input  wire logic            ack_in,
    input  wire logic            ackb_in,
    input  wire logic            atn_in,
    input  wire logic            wide_in,
    input  wire logic [DB_W-1:0] tx_data_in,
    input  wire logic            bus_rst_req_in,
    output logic [CTL_W-1:0]     bus_ctl_out,
    output logic [DB_W-1:0]      bus_db_out,
    output logic [LANES-1:0]     bus_par_out,
    scsdrv_if.init               bus
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [CTL_W-1:0] ctl_s1;
    logic [CTL_W-1:0] ctl_s2;
    logic [DB_W-1:0]  db_s1;
    logic [DB_W-1:0]  db_s2;
    logic [LANES-1:0] par_s1;
    logic [LANES-1:0] par_s2;
    logic [CTL_W-1:0] next_ctl_drv;
    logic [CTL_W-1:0] next_ctl_val;
    logic [DB_W-1:0]  next_db_drv;
    logic [DB_W-1:0]  next_db_val;
    logic [LANES-1:0] lane_on;
    logic [DB_W-1:0]  own_id_bit_drive;

    // Two-stage synchronisers, then a registered copy for the user
    always_ff @(posedge sys_clk_in) begin
        ctl_s1 <= bus.ctl;
        ctl_s2 <= ctl_s1;
        db_s1  <= bus.db;
        db_s2  <= db_s1;
        par_s1 <= bus.par;
        par_s2 <= par_s1;
        if (sys_rst_in) begin
            bus_ctl_out <= CTL_RST_VAL;
            bus_db_out  <= DB_RST_VAL;
            bus_par_out <= PAR_RST_VAL;
        end else begin
            bus_ctl_out <= ctl_s2;
            bus_db_out  <= db_s2;
            bus_par_out <= par_s2;
        end
    end

    assign own_id_bit_drive = DB_W'(1) << own_id_in;

    // ****************************************
    // Driver selection per phase
    // ****************************************
    always_comb begin
        next_ctl_drv = '0;
        next_ctl_val = '0;
        next_db_drv  = '0;
        next_db_val  = tx_data_in;
        lane_on      = '0;
        case (phase_in)
            PH_ARB: begin
                if (contend_in) begin
                    next_ctl_drv[L_BSY] = 1'b1;
                    next_ctl_val[L_BSY] = 1'b1;
                    next_db_drv         = own_id_bit_drive;
                    next_db_val         = own_id_bit_drive;
                    next_ctl_drv[L_SEL] = won_in;
                    next_ctl_val[L_SEL] = won_in;
                end
            end
            PH_SEL: begin
                next_ctl_drv[L_BSY] = bsy_in;
                next_ctl_val[L_BSY] = bsy_in;
                next_ctl_drv[L_SEL] = sel_in;
                next_ctl_val[L_SEL] = sel_in;
                next_ctl_drv[L_ATN] = 1'b1;
                next_ctl_val[L_ATN] = atn_in;
                next_db_drv         = DB_LOW_MASK;
                lane_on[0]          = 1'b1;
            end
            PH_RESEL, PH_CMD, PH_DIN, PH_DOUT, PH_STAT, PH_MIN, PH_MOUT: begin
                // Busy in reselection only while the initiator holds it
                if (phase_in == PH_RESEL) begin
                    next_ctl_drv[L_BSY] = bsy_in;
                    next_ctl_val[L_BSY] = bsy_in;
                end
                next_ctl_drv[L_ACK] = 1'b1;
                next_ctl_val[L_ACK] = ack_in;
                next_ctl_drv[L_ATN] = 1'b1;
                next_ctl_val[L_ATN] = atn_in;
                if (info_phase(phase_in) && !to_init(phase_in)) begin
                    next_db_drv = DB_LOW_MASK;
                    lane_on[0]  = 1'b1;
                end
                if (wide_in && (phase_in == PH_DIN || phase_in == PH_DOUT)) begin
                    next_ctl_drv[L_ACKB] = 1'b1;
                    next_ctl_val[L_ACKB] = ackb_in;
                end
                if (wide_in && phase_in == PH_DOUT) begin
                    next_db_drv = '1;
                    lane_on     = '1;
                end
            end
            default: begin
                next_ctl_drv = '0;
            end
        endcase
        next_ctl_drv[L_RST] = bus_rst_req_in;
        next_ctl_val[L_RST] = bus_rst_req_in;
    end

    // ****************************************
    // Pin driver registers
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || ctl_s2[L_RST]) begin
            bus.i_ctl_out  <= CTL_RST_VAL | {CTL_W{1'b0}};
            bus.i_ctl_oe_n <= ~CTL_RST_VAL;
            bus.i_db_out   <= DB_RST_VAL;
            bus.i_db_oe_n  <= ~DB_RST_VAL;
            bus.i_par_out  <= PAR_RST_VAL;
            bus.i_par_oe_n <= ~PAR_RST_VAL;
        end else begin
            bus.i_ctl_out  <= next_ctl_val;
            bus.i_ctl_oe_n <= ~next_ctl_drv;
            bus.i_db_out   <= next_db_val & next_db_drv;
            bus.i_db_oe_n  <= ~next_db_drv;
            // Odd parity per lane; arbitration never enables a lane
            for (int k = 0; k < LANES; k++) begin
                bus.i_par_out[k]  <= ~^next_db_val[8*k +: 8];
                bus.i_par_oe_n[k] <= ~lane_on[k];
            end
        end
    end

endmodule
`default_nettype wire

// File: hdl/scsdrv_pkg.sv
`default_nettype none
package scsdrv_pkg;

    // ****************************************
    // Bus phases seen by both ends
    // ****************************************
    typedef enum logic [3:0] {
        PH_FREE  = 4'h0,
        PH_ARB   = 4'h1,
        PH_SEL   = 4'h2,
        PH_RESEL = 4'h3,
        PH_CMD   = 4'h4,
        PH_DIN   = 4'h5,
        PH_DOUT  = 4'h6,
        PH_STAT  = 4'h7,
        PH_MIN   = 4'h8,
        PH_MOUT  = 4'h9
    } scsdrv_phase_e;

    // ****************************************
    // Control line positions and widths
    // ****************************************
    localparam int CTL_W    = 11;
    localparam int DB_W     = 32;
    localparam int LANES    = 4;
    localparam int L_BSY    = 0;
    localparam int L_SEL    = 1;
    localparam int L_CD     = 2;
    localparam int L_IO     = 3;
    localparam int L_MSG    = 4;
    localparam int L_REQ    = 5;
    localparam int L_ACK    = 6;
    localparam int L_ATN    = 7;
    localparam int L_RST    = 8;
    localparam int L_REQB   = 9;
    localparam int L_ACKB   = 10;

    // ****************************************
    // Reset values of the pin drivers
    // ****************************************
    localparam logic [CTL_W-1:0] CTL_RST_VAL = 11'h000;
    localparam logic [DB_W-1:0]  DB_RST_VAL  = 32'h0000_0000;
    localparam logic [LANES-1:0] PAR_RST_VAL = 4'h0;

    // Low data byte only, upper lanes belong to the wide extension
    localparam logic [DB_W-1:0]  DB_LOW_MASK = 32'h0000_00FF;

    // True when the phase is an information transfer phase
    function automatic logic info_phase(input scsdrv_phase_e ph);
        info_phase = (ph >= PH_CMD) && (ph <= PH_MOUT);
    endfunction

    // True when data flows from target to initiator
    function automatic logic to_init(input scsdrv_phase_e ph);
        to_init = (ph == PH_DIN) || (ph == PH_STAT) || (ph == PH_MIN);
    endfunction

endpackage
`default_nettype wire

// File: hdl/scsdrv_targ.sv
// Operation
// - Contenders assert busy during arbitration
// - Contender drives only own ID data bit
// - Arbitration parity released, never driven false
// - Only arbitration winner drives select
// - Initiator-owned lines driven only by initiator
// - Unsourced lines released to terminator false
// - Selection busy driven by either or both
// - Busy, select, reset OR-tied; reset anytime
// - Driven data bytes carry odd parity
// - Extension parity lanes cover upper bytes
`timescale 1ns/1ps
`default_nettype none
module scsdrv_targ
    import scsdrv_pkg::*;
(
    input  wire logic            sys_clk_in,
    input  wire logic            sys_rst_in,
    input  wire scsdrv_phase_e   phase_in,
    input  wire logic [2:0]      own_id_in,
    input  wire logic            contend_in,
    input  wire logic            won_in,
    input  wire logic            bsy_in,
    input  wire logic            req_in,
    input  wire logic            reqb_in,
    input  wire logic            wide_in,
    input  wire logic [DB_W-1:0] tx_data_in,
    input  wire logic            bus_rst_req_in,
    output logic [CTL_W-1:0]     bus_ctl_out,
    output logic [DB_W-1:0]      bus_db_out,
    output logic [LANES-1:0]     bus_par_out,
    output logic                 bus_reset_out,
    scsdrv_if.targ               bus
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [CTL_W-1:0] ctl_s1;
    logic [CTL_W-1:0] ctl_s2;
    logic [DB_W-1:0]  db_s1;
    logic [DB_W-1:0]  db_s2;
    logic [LANES-1:0] par_s1;
    logic [LANES-1:0] par_s2;
    logic             int_rst;
    logic [CTL_W-1:0] next_ctl_drv;
    logic [CTL_W-1:0] next_ctl_val;
    logic [DB_W-1:0]  next_db_drv;
    logic [DB_W-1:0]  next_db_val;
    logic [LANES-1:0] next_par_drv;
    logic [LANES-1:0] next_par_val;
    logic [LANES-1:0] par_odd;
    logic [LANES-1:0] lane_on;
    logic [DB_W-1:0]  own_id_bit_drive;
    logic [2:0]       phase_bits;

    // ****************************************
    // Bus input synchronisers
    // ****************************************

    // Two stages on every line before any logic reads it
    always_ff @(posedge sys_clk_in) begin
        ctl_s1 <= bus.ctl;
        ctl_s2 <= ctl_s1;
        db_s1  <= bus.db;
        db_s2  <= db_s1;
        par_s1 <= bus.par;
        par_s2 <= par_s1;
    end

    // Bus reset line also resets this end
    assign int_rst = sys_rst_in | ctl_s2[L_RST];

    // Sampled bus state handed to the user side
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            bus_ctl_out   <= CTL_RST_VAL;
            bus_db_out    <= DB_RST_VAL;
            bus_par_out   <= PAR_RST_VAL;
            bus_reset_out <= 1'b0;
        end else begin
            bus_ctl_out   <= ctl_s2;
            bus_db_out    <= db_s2;
            bus_par_out   <= par_s2;
            bus_reset_out <= ctl_s2[L_RST];
        end
    end

    // ****************************************
    // Phase line encoding
    // ****************************************

    // C/D, I/O, MSG values for each information phase
    always_comb begin
        case (phase_in)
            PH_CMD:  phase_bits = 3'h1;
            PH_DIN:  phase_bits = 3'h2;
            PH_DOUT: phase_bits = 3'h0;
            PH_STAT: phase_bits = 3'h3;
            PH_MIN:  phase_bits = 3'h7;
            PH_MOUT: phase_bits = 3'h5;
            default: phase_bits = 3'h0;
        endcase
    end

    // One-hot own identifier on the low byte
    assign own_id_bit_drive = DB_W'(1) << own_id_in;

    // ****************************************
    // Driver selection per phase
    // ****************************************

    // Everything starts released so unsourced lines float false
    always_comb begin
        next_ctl_drv = '0;
        next_ctl_val = '0;
        next_db_drv  = '0;
        next_db_val  = tx_data_in;
        lane_on      = '0;
        case (phase_in)
            PH_ARB: begin
                if (contend_in) begin
                    next_ctl_drv[L_BSY] = 1'b1;
                    next_ctl_val[L_BSY] = 1'b1;
                    next_db_drv         = own_id_bit_drive;
                    next_db_val         = own_id_bit_drive;
                    next_ctl_drv[L_SEL] = won_in;
                    next_ctl_val[L_SEL] = won_in;
                end
            end
            PH_SEL: begin
                // Target answers selection by raising busy
                next_ctl_drv[L_BSY] = bsy_in;
                next_ctl_val[L_BSY] = bsy_in;
            end
            PH_RESEL: begin
                next_ctl_drv[L_BSY] = bsy_in;
                next_ctl_val[L_BSY] = bsy_in;
                next_ctl_drv[L_SEL] = won_in;
                next_ctl_val[L_SEL] = won_in;
                next_ctl_drv[L_IO]  = 1'b1;
                next_ctl_val[L_IO]  = 1'b1;
                next_db_drv         = DB_LOW_MASK;
                lane_on[0]          = 1'b1;
            end
            PH_CMD, PH_DIN, PH_DOUT, PH_STAT, PH_MIN, PH_MOUT: begin
                next_ctl_drv[L_BSY] = 1'b1;
                next_ctl_val[L_BSY] = 1'b1;
                next_ctl_drv[L_REQ] = 1'b1;
                next_ctl_val[L_REQ] = req_in;
                next_ctl_drv[L_CD]  = 1'b1;
                next_ctl_drv[L_IO]  = 1'b1;
                next_ctl_drv[L_MSG] = 1'b1;
                next_ctl_val[L_CD]  = phase_bits[0];
                next_ctl_val[L_IO]  = phase_bits[1];
                next_ctl_val[L_MSG] = phase_bits[2];
                if (to_init(phase_in)) begin
                    next_db_drv = DB_LOW_MASK;
                    lane_on[0]  = 1'b1;
                end
                if (wide_in && (phase_in == PH_DIN || phase_in == PH_DOUT)) begin
                    next_ctl_drv[L_REQB] = 1'b1;
                    next_ctl_val[L_REQB] = reqb_in;
                end
                if (wide_in && phase_in == PH_DIN) begin
                    next_db_drv = '1;
                    lane_on     = '1;
                end
            end
            default: begin
                next_ctl_drv = '0;
            end
        endcase
        // Bus reset may be raised in any phase
        next_ctl_drv[L_RST] = bus_rst_req_in;
        next_ctl_val[L_RST] = bus_rst_req_in;
    end

    // ****************************************
    // Odd parity per data lane
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_par
            // Parity bit makes the count of ones in the lane odd
            assign par_odd[g]      = ~^next_db_val[8*g +: 8];
            assign next_par_val[g] = par_odd[g];
            // Arbitration leaves parity released rather than false
            assign next_par_drv[g] = lane_on[g] && (phase_in != PH_ARB);
        end
    endgenerate

    // ****************************************
    // Pin driver registers
    // ****************************************

    // OR-tied lines only ever enable when showing true
    always_ff @(posedge sys_clk_in) begin
        if (int_rst) begin
            bus.t_ctl_out  <= CTL_RST_VAL;
            bus.t_ctl_oe_n <= ~CTL_RST_VAL;
        end else begin
            bus.t_ctl_out  <= next_ctl_val;
            bus.t_ctl_oe_n <= ~next_ctl_drv;
        end
    end

    // Data and parity drivers release under either reset
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            bus.t_db_out   <= DB_RST_VAL;
            bus.t_db_oe_n  <= ~DB_RST_VAL;
            bus.t_par_out  <= PAR_RST_VAL;
            bus.t_par_oe_n <= ~PAR_RST_VAL;
        end else if (ctl_s2[L_RST]) begin
            bus.t_db_out   <= DB_RST_VAL;
            bus.t_db_oe_n  <= ~DB_RST_VAL;
            bus.t_par_out  <= PAR_RST_VAL;
            bus.t_par_oe_n <= ~PAR_RST_VAL;
        end else begin
            bus.t_db_out   <= next_db_val & next_db_drv;
            bus.t_db_oe_n  <= ~next_db_drv;
            bus.t_par_out  <= next_par_val;
            bus.t_par_oe_n <= ~next_par_drv;
        end
    end

endmodule
`default_nettype wire

// File: sim/scsdrv_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module scsdrv_asserts
    import scsdrv_pkg::*;
(
    input wire logic             sys_clk_in,
    input wire logic             sys_rst_in,
    input wire logic [CTL_W-1:0] i_ctl_out,
    input wire logic [CTL_W-1:0] i_ctl_oe_n,
    input wire logic [DB_W-1:0]  i_db_out,
    input wire logic [DB_W-1:0]  i_db_oe_n,
    input wire logic [LANES-1:0] i_par_out,
    input wire logic [LANES-1:0] i_par_oe_n,
    input wire logic [CTL_W-1:0] t_ctl_out,
    input wire logic [CTL_W-1:0] t_ctl_oe_n,
    input wire logic [DB_W-1:0]  t_db_out,
    input wire logic [DB_W-1:0]  t_db_oe_n,
    input wire logic [LANES-1:0] t_par_out,
    input wire logic [LANES-1:0] t_par_oe_n,
    input wire logic [CTL_W-1:0] ctl
);
    // ****************************************
    // Line groups by owner
    // ****************************************
    localparam logic [CTL_W-1:0] OR_MASK = (CTL_W'(1) << L_BSY) | (CTL_W'(1) << L_SEL) | (CTL_W'(1) << L_RST);
    localparam logic [CTL_W-1:0] I_MASK  = (CTL_W'(1) << L_ACK) | (CTL_W'(1) << L_ATN) | (CTL_W'(1) << L_ACKB);
    localparam logic [CTL_W-1:0] T_MASK  = (CTL_W'(1) << L_CD) | (CTL_W'(1) << L_IO) | (CTL_W'(1) << L_MSG)
                                         | (CTL_W'(1) << L_REQ) | (CTL_W'(1) << L_REQB);

    // True when every enabled parity lane in lo..hi makes its byte odd
    function automatic logic lanes_odd(input logic [DB_W-1:0] d, input logic [LANES-1:0] p,
                                       input logic [LANES-1:0] p_oe_n, input int lo, input int hi);
        lanes_odd = 1'b1;
        for (int l = lo; l <= hi; l++) begin
            if (!p_oe_n[l] && !(^{d[8*l +: 8], p[l]})) begin
                lanes_odd = 1'b0;
            end
        end
    endfunction

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);

    // ****************************************
    // Ownership and drive level
    // ****************************************
    sel_one_src_a: assert property (!(!i_ctl_oe_n[L_SEL] && !t_ctl_oe_n[L_SEL]))
        else $error("select enabled by both ends");
    targ_init_lines_a: assert property ((~t_ctl_oe_n & I_MASK) == '0)
        else $error("target enabled an initiator line");
    init_targ_lines_a: assert property ((~i_ctl_oe_n & T_MASK) == '0)
        else $error("initiator enabled a target line");
    or_tied_true_a: assert property (!(((~i_ctl_oe_n & ~i_ctl_out) | (~t_ctl_oe_n & ~t_ctl_out)) & OR_MASK))
        else $error("OR-tied line driven false");
    req_with_bsy_a: assert property (!t_ctl_oe_n[L_REQ] |-> !t_ctl_oe_n[L_BSY] && t_ctl_out[L_BSY])
        else $error("request driven without busy");
    db_one_src_a: assert property ((~i_db_oe_n & ~t_db_oe_n) == '0)
        else $error("data bit enabled by both ends");

    // ****************************************
    // Parity
    // ****************************************
    par_low_odd_a: assert property (lanes_odd(i_db_out, i_par_out, i_par_oe_n, 0, 0)
                                    && lanes_odd(t_db_out, t_par_out, t_par_oe_n, 0, 0))
        else $error("low byte parity not odd");
    par_wide_odd_a: assert property (lanes_odd(i_db_out, i_par_out, i_par_oe_n, 1, 3)
                                     && lanes_odd(t_db_out, t_par_out, t_par_oe_n, 1, 3))
        else $error("extension parity not odd");
    par_full_byte_a: assert property ((!i_par_oe_n[0] |-> i_db_oe_n[7:0] == 8'h00)
                                      and (!t_par_oe_n[0] |-> t_db_oe_n[7:0] == 8'h00))
        else $error("parity driven without a full byte");

    // Main scenarios reached
    arb_win_c: cover property (!i_ctl_oe_n[L_SEL] && !t_ctl_oe_n[L_BSY] && !i_ctl_oe_n[L_BSY]);
    wide_xfer_c: cover property (!t_par_oe_n[3] ##1 !i_par_oe_n[3] [*2]);
    bus_rst_c: cover property (ctl[L_RST]);
endmodule
`default_nettype wire

// File: sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import scsdrv_pkg::*;

    // ****************************************
    // Stimulus and observation
    // ****************************************
    logic             sys_clk_in;
    logic             sys_rst_in;
    scsdrv_phase_e    phase;
    logic             wide, req, reqb, sel, ack, ackb, atn, hit;
    logic [2:0]       i_id, t_id;
    logic             i_cont, t_cont, i_won, t_won, i_bsy, t_bsy, i_rrq, t_rrq, t_rst_out;
    logic [DB_W-1:0]  i_tx, t_tx, src, i_bdo, t_bdo;
    logic [CTL_W-1:0] t_bco, i_bco, exp_ctl;
    logic [LANES-1:0] lanes, i_bpo, t_bpo;
    int               miscompares = 0;
    int               tests_run = 0;
    int               cycles = 0;
    scsdrv_phase_e    ph_tab [6] = '{PH_CMD, PH_DIN, PH_DOUT, PH_STAT, PH_MIN, PH_MOUT};
    logic [2:0]       typ_tab [6] = '{3'h1, 3'h2, 3'h0, 3'h3, 3'h7, 3'h5};
    logic [5:0]       tsrc = 6'h1A;

    scsdrv_if bus_if ();

    scsdrv_init u_scsdrv_init (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .phase_in(phase),
        .own_id_in(i_id), .contend_in(i_cont), .won_in(i_won), .bsy_in(i_bsy), .sel_in(sel), .ack_in(ack),
        .ackb_in(ackb), .atn_in(atn), .wide_in(wide), .tx_data_in(i_tx), .bus_rst_req_in(i_rrq),
        .bus_ctl_out(i_bco), .bus_db_out(i_bdo), .bus_par_out(i_bpo), .bus(bus_if));
    scsdrv_targ u_scsdrv_targ (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .phase_in(phase),
        .own_id_in(t_id), .contend_in(t_cont), .won_in(t_won), .bsy_in(t_bsy), .req_in(req), .reqb_in(reqb),
        .wide_in(wide), .tx_data_in(t_tx), .bus_rst_req_in(t_rrq), .bus_ctl_out(t_bco), .bus_db_out(t_bdo),
        .bus_par_out(t_bpo), .bus_reset_out(t_rst_out), .bus(bus_if));
    scsdrv_asserts u_scsdrv_asserts (.sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .i_ctl_out(bus_if.i_ctl_out), .i_ctl_oe_n(bus_if.i_ctl_oe_n), .i_db_out(bus_if.i_db_out),
        .i_db_oe_n(bus_if.i_db_oe_n), .i_par_out(bus_if.i_par_out), .i_par_oe_n(bus_if.i_par_oe_n),
        .t_ctl_out(bus_if.t_ctl_out), .t_ctl_oe_n(bus_if.t_ctl_oe_n), .t_db_out(bus_if.t_db_out),
        .t_db_oe_n(bus_if.t_db_oe_n), .t_par_out(bus_if.t_par_out), .t_par_oe_n(bus_if.t_par_oe_n),
        .ctl(bus_if.ctl));

    // Clock and hang guard
    initial begin
        sys_clk_in = 1'b0;
        forever #4 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            miscompares++;
            close_out();
        end
    end

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [3:0] odd_par(input logic [31:0] d);
        for (int l = 0; l < 4; l++) begin
            odd_par[l] = ~^d[8*l +: 8];
        end
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {wide, req, reqb, sel, ack, ackb, atn, i_bsy, t_bsy, i_rrq, t_rrq} = '0;
        phase = PH_ARB;
        {i_id, t_id, i_cont, t_cont, i_won, t_won} = {3'h7, 3'h2, 4'hE};
        i_tx = 32'hFFFF_FFFF;
        t_tx = 32'hFFFF_FFFF;
        sys_rst_in = 1'b1;
        repeat (16) @(negedge sys_clk_in);
        sys_rst_in = 1'b0;
        // Arbitration: both contend with initiator winning, then target contends alone and wins; data present but not driven
        @(negedge sys_clk_in);
        chk(32'(bus_if.ctl), 32'h003);
        chk(bus_if.db, 32'h0000_0084);
        chk(32'(bus_if.par), 32'h0);
        chk(32'(bus_if.t_ctl_oe_n[L_SEL]), 32'h1);
        {i_cont, i_won, t_won} = 3'h1;
        @(negedge sys_clk_in);
        chk(32'(bus_if.ctl), 32'h003);
        chk(bus_if.db, 32'h0000_0004);
        // Selection, busy from either end
        phase = PH_SEL;
        {t_cont, t_won, sel, atn, t_bsy, i_tx} = {5'h0F, 32'hFFFF_FF81};
        @(negedge sys_clk_in);
        chk(32'(bus_if.ctl), 32'h083);
        chk(bus_if.db, 32'h0000_0081);
        chk(32'(bus_if.par), 32'h1);
        {i_bsy, t_bsy} = 2'h2;
        @(negedge sys_clk_in);
        chk(32'(bus_if.ctl), 32'h083);
        // Reselection driven by the target
        phase = PH_RESEL;
        {t_bsy, t_won, sel, atn, i_bsy, t_tx} = {5'h18, 32'h0000_0003};
        @(negedge sys_clk_in);
        chk(32'(bus_if.ctl), 32'h00B);
        chk(bus_if.db, 32'h0000_0003);
        chk(32'(bus_if.par), 32'h1);
        // Information phases, narrow then wide
        {t_won, req, reqb, ack, ackb} = 5'h0F;
        i_tx = 32'h0137_7E3C;
        t_tx = 32'hF0E1_0CC7;
        for (int w = 0; w < 2; w++) begin
            for (int k = 0; k < 6; k++) begin
                phase = ph_tab[k];
                wide = w[0];
                @(negedge sys_clk_in);
                lanes = (w == 1 && (ph_tab[k] == PH_DIN || ph_tab[k] == PH_DOUT)) ? 4'hF : 4'h1;
                src = (tsrc[k] ? t_tx : i_tx) & {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, 8'hFF};
                exp_ctl = 11'h061 | {6'h00, typ_tab[k], 2'h0} | (lanes[3] ? 11'h600 : 11'h000);
                chk(32'(bus_if.ctl), 32'(exp_ctl));
                chk(bus_if.db, src);
                chk(32'(bus_if.par[0]), 32'(odd_par(src) & 4'h1));
                chk(32'(bus_if.par[3:1]), 32'(odd_par(src) >> 1 & lanes >> 1));
                repeat (3) @(negedge sys_clk_in);
                chk(32'(t_bco), 32'(exp_ctl));
                chk(32'(i_bco), 32'(exp_ctl));
                chk(i_bdo, src);
                chk(t_bdo, src);
                chk(32'(i_bpo), 32'(odd_par(src) & lanes));
                chk(32'(t_bpo), 32'(odd_par(src) & lanes));
            end
        end
        // Bus free with every request still high
        phase = PH_FREE;
        @(negedge sys_clk_in);
        chk(32'(bus_if.ctl), 32'h000);
        chk(bus_if.db | 32'(bus_if.par), 32'h0);
        // Reset pulse from each end in turn
        for (int e = 0; e < 2; e++) begin
            {i_rrq, t_rrq} = (e == 0) ? 2'h2 : 2'h1;
            @(negedge sys_clk_in);
            chk(32'(bus_if.ctl[L_RST]), 32'h1);
            {i_rrq, t_rrq} = 2'h0;
            hit = 1'b0;
            repeat (8) begin
                @(negedge sys_clk_in);
                if (t_rst_out === 1'b1) hit = 1'b1;
            end
            chk(32'(hit), 32'h1);
        end
        close_out();
    end
endmodule
`default_nettype wire
